// *** core/wos_pkg.sv ***
// Constants, field layouts and types of the watchdog overflow supervisor.
// Assumes one 125 MHz system clock that is also the high-frequency count base.
package wos_pkg;

  // Bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL_A = 8'h34;
  localparam logic [7:0] IDX_COMMAND = 8'h35;
  localparam logic [7:0] IDX_STATUS = 8'h36;
  localparam logic [7:0] IDX_CLOCK_CFG = 8'h37;

  // Command codes of the command port
  localparam logic [7:0] CMD_CLEAR = 8'h4E;
  localparam logic [7:0] CMD_DISABLE = 8'hB1;
  localparam logic [7:0] CMD_TRAP_AREA = 8'hD2;

  // Control A field positions
  localparam int RUN_BIT_POS = 3;
  localparam int TIME_LSB = 1;
  localparam int ACTION_POS = 0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Overflow period exponents for selection 00; each step divides by four
  localparam int HF_EXP_SEL0 = 25;
  localparam int LF_EXP_SEL0 = 17;
  localparam int EXP_STEP = 2;
  // Two binary counter stages take the top two bits of the period
  localparam int BIN_STAGES = 2;
  localparam int DIV_W = HF_EXP_SEL0 - BIN_STAGES;

  // Internal reset request length: at most 24 high-frequency periods
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_MAX_NS = 192;
  localparam int RESET_CYCLES = RESET_MAX_NS / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 5;

  // Reset values of control A fields
  localparam logic RUN_BIT_RESET = 1'b1;
  localparam logic [1:0] TIME_RESET = 2'h0;
  localparam logic ACTION_RESET = 1'b1;

  // Overflow action selector encodings
  localparam logic ACTION_IRQ = 1'b0;
  localparam logic ACTION_RESET_REQ = 1'b1;

  // Software view of control A
  typedef struct packed {
    logic watchdog_run_bit;
    logic [1:0] detect_time_sel;
    logic overflow_action_sel;
  } wos_ctrl_t;

  // Read-only status word
  typedef struct packed {
    logic reset_req;
    logic [1:0] bin_count;
    logic active;
    logic watchdog_run_bit;
    logic [1:0] detect_time_sel;
    logic overflow_action_sel;
  } wos_status_t;

endpackage : wos_pkg

// *** core/wos_supervisor.sv ***
// Watchdog overflow supervisor: prescale divider, two-stage binary counter,
// overflow action select, and an AXI4-Lite slave for its registers.
// Assumes all inputs are synchronous to aclk; low_freq_tick is a one-cycle
// enable at the low-frequency clock rate from the clock generator.
`timescale 1ns/1ns
module wos_supervisor
  import wos_pkg::*;
#(
  parameter int HF_EXP = HF_EXP_SEL0, // Period exponent for selection 00, fast clock
  parameter int LF_EXP = LF_EXP_SEL0 // Period exponent for selection 00, slow clock
) (
  input wire logic aclk, // System clock, high-frequency base
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [AXI_ADDR_W-1:0] awaddr, // Write address
  input wire logic [2:0] awprot, // Write protection, unused
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [AXI_DATA_W-1:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [AXI_ADDR_W-1:0] araddr, // Read address
  input wire logic [2:0] arprot, // Read protection, unused
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [AXI_DATA_W-1:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic low_freq_tick, // One pulse per low-frequency clock period
  input wire logic slow_mode, // CPU runs from the low-frequency clock
  input wire logic halt_mode, // Halt mode, oscillator warm-up included
  input wire logic idle_mode, // Idle mode
  input wire logic sleep_mode, // Sleep mode
  output logic watchdog_irq, // Overflow interrupt request, one-cycle pulse
  output logic watchdog_reset_req // Internal reset request, active high
);

  // Number of divider bits in front of the binary counter for a selection
  function automatic logic [4:0] div_bits(input logic [1:0] sel, input logic lf);
    int e;
    e = (lf ? LF_EXP : HF_EXP) - EXP_STEP * int'(sel) - BIN_STAGES;
    return 5'(e);
  endfunction : div_bits

  // Byte address of a register index
  function automatic logic [AXI_ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    return AXI_ADDR_W'({idx, 2'b00});
  endfunction : reg_addr

  wos_ctrl_t ctrl_q;
  logic active_q;
  logic low_src_q;
  logic [DIV_W-1:0] div_q;
  logic [BIN_STAGES-1:0] bin_q;
  logic [RST_CNT_W-1:0] rst_cnt_q;

  // Bus holding state
  logic aw_have_q;
  logic w_have_q;
  logic [AXI_ADDR_W-1:0] aw_addr_q;
  logic [AXI_DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [AXI_DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic irq_q;

  logic aw_fire;
  logic w_fire;
  logic wr_do;
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_cfg;
  logic wr_hit;
  logic [7:0] wr_byte;
  logic cmd_clear;
  logic cmd_disable;
  logic paused;
  logic base_tick;
  logic [DIV_W-1:0] tap_mask;
  logic carry;
  logic overflow;

  // Handshakes and write decode; only byte lane 0 carries register data
  assign aw_fire = awvalid && awready_q;
  assign w_fire = wvalid && wready_q;
  assign wr_do = aw_have_q && w_have_q && !bvalid_q;
  assign wr_lane0 = w_strb_q[0];
  assign wr_byte = w_data_q[7:0];
  assign wr_ctrl = wr_do && wr_lane0 && (aw_addr_q == reg_addr(IDX_CONTROL_A));
  assign wr_cmd = wr_do && wr_lane0 && (aw_addr_q == reg_addr(IDX_COMMAND));
  assign wr_cfg = wr_do && wr_lane0 && (aw_addr_q == reg_addr(IDX_CLOCK_CFG));
  assign wr_hit = (aw_addr_q == reg_addr(IDX_CONTROL_A)) ||
                  (aw_addr_q == reg_addr(IDX_COMMAND)) ||
                  (aw_addr_q == reg_addr(IDX_CLOCK_CFG));

  // Command decode; D2 is accepted but the trap logic lives elsewhere
  assign cmd_clear = wr_cmd && (wr_byte == CMD_CLEAR);
  assign cmd_disable = wr_cmd && (wr_byte == CMD_DISABLE) &&
                       !ctrl_q.watchdog_run_bit;

  // Count base: fast clock every cycle, slow clock on its tick
  assign paused = halt_mode || idle_mode || sleep_mode;
  assign base_tick = (low_src_q || slow_mode) ? low_freq_tick : 1'b1;
  assign tap_mask = (DIV_W'(1) << div_bits(ctrl_q.detect_time_sel,
                    low_src_q || slow_mode)) - DIV_W'(1);
  assign carry = active_q && !paused && base_tick &&
                 ((div_q & tap_mask) == tap_mask);
  assign overflow = carry && (bin_q == {BIN_STAGES{1'b1}}) && !cmd_clear;

  // Write address channel: take one address, hold it until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      awready_q <= 1'b0;
    end else begin
      awready_q <= awvalid && !awready_q && !aw_have_q && !bvalid_q;
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_do) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  // Write data channel, independent of the address so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      wready_q <= 1'b0;
    end else begin
      wready_q <= wvalid && !wready_q && !w_have_q && !bvalid_q;
      if (w_fire) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr_do) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response once both halves are in; unmapped addresses get an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read channel; control A and command port are write-only and read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= arvalid && !arready_q && !rvalid_q;
      if (arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= RESP_OKAY;
        rdata_q <= '0;
        if (araddr == reg_addr(IDX_STATUS)) begin
          rdata_q <= AXI_DATA_W'(wos_status_t'{
            reset_req: rst_cnt_q != '0,
            bin_count: bin_q,
            active: active_q,
            watchdog_run_bit: ctrl_q.watchdog_run_bit,
            detect_time_sel: ctrl_q.detect_time_sel,
            overflow_action_sel: ctrl_q.overflow_action_sel});
        end else if (araddr == reg_addr(IDX_CLOCK_CFG)) begin
          rdata_q <= AXI_DATA_W'(low_src_q);
        end else if (araddr != reg_addr(IDX_CONTROL_A) &&
                     araddr != reg_addr(IDX_COMMAND)) begin
          rresp_q <= RESP_SLVERR;
        end
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Control A fields; the action selector can only ever fall
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q.watchdog_run_bit <= RUN_BIT_RESET;
      ctrl_q.detect_time_sel <= TIME_RESET;
      ctrl_q.overflow_action_sel <= ACTION_RESET;
    end else if (wr_ctrl) begin
      ctrl_q.watchdog_run_bit <= wr_byte[RUN_BIT_POS];
      ctrl_q.detect_time_sel <= wr_byte[TIME_LSB +: 2];
      ctrl_q.overflow_action_sel <= ctrl_q.overflow_action_sel &
                                    wr_byte[ACTION_POS];
    end
  end

  // Clock source select, software owned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_src_q <= 1'b0;
    end else if (wr_cfg) begin
      low_src_q <= wr_byte[0];
    end
  end

  // Running state: starts at reset; run bit 0 alone leaves it running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 1'b1;
    end else if (cmd_disable) begin
      active_q <= 1'b0;
    end else if (wr_ctrl && wr_byte[RUN_BIT_POS]) begin
      active_q <= 1'b1;
    end
  end

  // Prescale divider; a clear code does not touch it, so the next overflow
  // can come as early as three quarters of the selected period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
    end else if (!active_q) begin
      div_q <= '0;
    end else if (!paused && base_tick) begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // Two-stage binary counter; clear wins over a carry in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bin_q <= '0;
    end else if (!active_q || cmd_clear) begin
      bin_q <= '0;
    end else if (carry) begin
      bin_q <= bin_q + BIN_STAGES'(1);
    end
  end

  // Interrupt pulse on overflow in interrupt mode; also a periodic tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= overflow && (ctrl_q.overflow_action_sel == ACTION_IRQ);
    end
  end

  // Reset request stretched to a fixed length no longer than allowed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_q <= '0;
    end else if (overflow && (ctrl_q.overflow_action_sel == ACTION_RESET_REQ)) begin
      rst_cnt_q <= RST_CNT_W'(RESET_CYCLES);
    end else if (rst_cnt_q != '0) begin
      rst_cnt_q <= rst_cnt_q - RST_CNT_W'(1);
    end
  end

  // Request output registered so it never glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_reset_req <= 1'b0;
    end else begin
      watchdog_reset_req <= (rst_cnt_q > RST_CNT_W'(1)) ||
        (overflow && (ctrl_q.overflow_action_sel == ACTION_RESET_REQ));
    end
  end

  // Port drive, all from flip-flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign watchdog_irq = irq_q;

endmodule : wos_supervisor

// *** testbench/wos_supervisor_properties.sv ***
// Port assertions for the watchdog overflow supervisor.
// Assumes it is bound to wos_supervisor and sees only its ports.
`timescale 1ns/1ns
module wos_checker
  import wos_pkg::*;
#(
  parameter int HF_EXP = 10, // Fast period exponent
  parameter int LF_EXP = 9 // Slow period exponent
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic awvalid, // Write address valid
  input wire logic awready, // Write address ready
  input wire logic [AXI_ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  input wire logic arready, // Read address ready
  input wire logic [1:0] bresp, // Write response
  input wire logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [1:0] rresp, // Read response
  input wire logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic halt_mode, // Halt
  input wire logic idle_mode, // Idle
  input wire logic sleep_mode, // Sleep
  input wire logic watchdog_irq, // Overflow interrupt
  input wire logic watchdog_reset_req // Internal reset request
);
  logic [4:0] rlen_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Length of the running reset request, so the 24-cycle bound stays cheap
  always_ff @(posedge aclk) begin
    if (!aresetn || !watchdog_reset_req) rlen_q <= 5'h00;
    else rlen_q <= rlen_q + 5'h01;
  end
  a_irq_one_cycle: assert property (watchdog_irq |=> !watchdog_irq)
    else $error("irq wider than one cycle");
  a_rst_max_len: assert property (watchdog_reset_req |-> rlen_q < 5'h18)
    else $error("reset request too long");
  a_rst_full_len: assert property ($fell(watchdog_reset_req) |-> rlen_q == 5'h18)
    else $error("reset request length wrong");
  a_pause_no_event: assert property ((halt_mode || idle_mode || sleep_mode) |=>
    !watchdog_irq && !$rose(watchdog_reset_req)) else $error("overflow while paused");
  a_one_action: assert property (!(watchdog_irq && $rose(watchdog_reset_req)))
    else $error("both overflow actions at once");
  a_aw_pulse: assert property (awready |=> !awready) else $error("awready held");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rresp)) else $error("read answer dropped");
  a_b_answer: assert property (awvalid && awready |-> ##[1:3] bvalid) else $error("no write answer");
  a_r_answer: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
  a_unmapped_err: assert property (arvalid && arready && !(araddr inside {8'hD0, 8'hD4, 8'hD8, 8'hDC})
    |=> rresp == RESP_SLVERR) else $error("unmapped read not refused");
  // Main scenarios
  c_irq: cover property (watchdog_irq);
  c_rst: cover property ($rose(watchdog_reset_req));
  c_err: cover property (rvalid && rready && rresp == RESP_SLVERR);
endmodule : wos_checker

bind wos_supervisor wos_checker #(.HF_EXP(HF_EXP), .LF_EXP(LF_EXP)) u_chk (.aclk, .aresetn, .awvalid,
  .awready, .araddr, .arvalid, .arready, .bresp, .bvalid, .bready, .rresp, .rvalid, .rready, .halt_mode,
  .idle_mode, .sleep_mode, .watchdog_irq, .watchdog_reset_req);

// *** testbench/test_watchdog_overflow_supervisor.sv ***
// Self-checking bench for the watchdog overflow supervisor.
// Assumes shortened counts: fast exponent 10, slow exponent 9.
`timescale 1ns/1ns
module test_watchdog_overflow_supervisor;
  import wos_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, low_freq_tick = 1'b0, slow_mode = 1'b0;
  logic halt_mode = 1'b0, idle_mode = 1'b0, sleep_mode = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, watchdog_irq, watchdog_reset_req;
  logic [1:0] bresp, rresp, rsp, tdiv = 2'h0;
  int miscompares = 0, n_checks = 0, cyc = 0, rel = 0, nirq = 0, nrst = 0, n0 = 0;

  wos_supervisor #(.HF_EXP(10), .LF_EXP(9)) dut_u (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .low_freq_tick, .slow_mode, .halt_mode, .idle_mode, .sleep_mode, .watchdog_irq,
    .watchdog_reset_req);

  always #4 aclk = ~aclk;

  // Slow tick every fourth cycle, event tallies and the hang limit
  always @(posedge aclk) begin
    tdiv <= tdiv + 2'h1;
    low_freq_tick <= (tdiv == 2'h3);
    cyc <= cyc + 1;
    if (watchdog_irq === 1'b1) nirq <= nirq + 1;
    if (watchdog_reset_req === 1'b1) nrst <= nrst + 1;
    if (cyc > 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // Compare and tally
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  // Bus read into rd and rsp
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rdr

  // Defaults after release, then the first overflow as a reset request
  task automatic t_defaults();
    int n;
    rdr(8'hD0);
    chk(rd, 32'h0, "control read");
    rdr(8'hD8);
    chk(rd & 32'h9F, 32'h19, "reset fields");
    rdr(8'hE0);
    chk(32'(rsp), 32'(RESP_SLVERR), "unmapped read");
    wr(8'hE0, 8'h00);
    chk(32'(rsp), 32'(RESP_SLVERR), "unmapped write");
    while (watchdog_reset_req !== 1'b1 && cyc - rel < 1100) @(posedge aclk);
    chk(32'(cyc - rel inside {[1020:1030]}), 32'h1, "first overflow time");
    n = 0;
    while (watchdog_reset_req === 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n), 32'h18, "reset length");
    $display("t_defaults done");
  endtask : t_defaults

  // Interrupt mode as a periodic timer; the selector cannot go back
  task automatic t_irq();
    wr(8'hD0, 8'h0E);
    chk(32'(rsp), 32'(RESP_OKAY), "control write answer");
    n0 = nirq;
    rel = nrst;
    repeat (160) @(posedge aclk);
    chk(32'(nirq - n0 inside {[9:11]}), 32'h1, "irq rate");
    chk(32'(nrst - rel), 32'h0, "no reset in irq mode");
    wr(8'hD0, 8'h0F);
    rdr(8'hD8);
    chk(rd & 32'h0F, 32'h0E, "selector stays low");
    $display("t_irq done");
  endtask : t_irq

  // Clear code holds off overflow, other codes do not; divider keeps running
  task automatic t_clear();
    int n;
    logic [7:0] codes [4] = '{8'h00, CMD_TRAP_AREA, 8'h4F, 8'hFF};
    // First clear lands before the tally starts, so an overflow already in flight is not counted
    wr(8'hD4, CMD_CLEAR);
    n0 = nirq;
    // Clears are paced by the bench, never sent in answer to an interrupt
    repeat (19) wr(8'hD4, CMD_CLEAR);
    chk(32'(nirq - n0), 32'h0, "clear holds off");
    n0 = nirq;
    repeat (5) foreach (codes[i]) wr(8'hD4, codes[i]);
    chk(32'(nirq - n0 >= 4), 32'h1, "others ignored");
    wr(8'hD4, CMD_CLEAR);
    n = 0;
    while (watchdog_irq !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n inside {[10:17]}), 32'h1, "first overflow after clear");
    $display("t_clear done");
  endtask : t_clear

  // Each low-power mode holds the count
  task automatic t_pause();
    logic [1:0] b0;
    for (int m = 0; m < 3; m++) begin
      wr(8'hD4, CMD_CLEAR);
      {halt_mode, idle_mode, sleep_mode} <= 3'h4 >> m;
      rdr(8'hD8);
      b0 = rd[6:5];
      n0 = nirq;
      repeat (60) @(posedge aclk);
      rdr(8'hD8);
      chk(32'(rd[6:5]), 32'(b0), "count held");
      chk(32'(nirq - n0), 32'h0, "no irq paused");
      {halt_mode, idle_mode, sleep_mode} <= 3'h0;
      // The clear starts on the next edge, so no mode pin is driven twice in one step
      wr(8'hD4, CMD_CLEAR);
    end
    $display("t_pause done");
  endtask : t_pause

  // Disable needs run bit low and then the disable code; run bit low alone keeps counting
  task automatic t_disable();
    for (int s = 0; s < 4; s++) begin
      if (s == 1) wr(8'hD4, CMD_CLEAR);
      if (s == 1) wr(8'hD0, 8'h06);
      wr(8'hD4, s[0] ? 8'h00 : CMD_DISABLE);
      if (s == 3) wr(8'hD0, 8'h0E);
      n0 = nirq;
      repeat (50) @(posedge aclk);
      chk(32'((nirq - n0 >= 2) == (s != 2)), 32'h1, "disable step");
      if (s == 2) rdr(8'hD8);
      if (s == 2) chk(rd & 32'h70, 32'h0, "held cleared");
    end
    $display("t_disable done");
  endtask : t_disable

  // Slow base from the mode input, then from the source select register
  task automatic t_slow();
    for (int s = 0; s < 2; s++) begin
      if (s == 1) wr(8'hDC, 8'h01);
      slow_mode <= (s == 0);
      n0 = nirq;
      repeat (320) @(posedge aclk);
      chk(32'(nirq - n0 inside {[9:11]}), 32'h1, "slow period");
    end
    rdr(8'hDC);
    chk(rd, 32'h1, "source select");
    $display("t_slow done");
  endtask : t_slow

  // Counts and verdict
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rel = cyc;
    t_defaults();
    t_irq();
    t_clear();
    t_pause();
    t_disable();
    t_slow();
    end_of_test();
  end
endmodule : test_watchdog_overflow_supervisor
